/* rtl/fcm_ctrl.sv */
// fuse-check mode control: arm, activate, count tms rises, gate current
// How it works
// R1: the continuity check runs only on the first port access per reset.
// R2: enter the mode on first tms fall, or tms low at reset.
// R3: while active, count tms rises; leave on the second one.
// R4: after leaving, stay inactive whatever tms does until next reset.
// R5: current path enabled only while mode active and tms low.
// R6: the tool should idle tms high to avoid accidental activation.
// R7: reset clears active and count, sets armed; entry clears armed; exit clears count.
`timescale 1ns/1ps
`default_nettype none
module fcm_ctrl
  import fcm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic tms,
  output var  logic fuse_check_active,
  output var  logic fuse_check_armed,
  output var  logic check_current_en
);

  typedef struct packed {
    fcm_state_e           state;
    logic [FCM_CNT_W-1:0] rises;
  } fcm_ctrl_s;

  fcm_ctrl_s st;
  fcm_ctrl_s next_st;

  fcm_edge_if edges ();

  fcm_tms_edge u_edge (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tms     (tms),
    .edges   (edges)
  );

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st.state)
      FCM_ARMED: begin
        if (edges.tms_fall) begin
          next_st.state = FCM_ACTIVE; // [R2]
          next_st.rises = FCM_CNT_RST;
        end
      end
      FCM_ACTIVE: begin
        if (edges.tms_rise) begin
          if (st.rises + 2'h1 == FCM_RISES_TO_EXIT) begin
            next_st.state = FCM_SPENT; // [R3] [R7]
            next_st.rises = FCM_CNT_RST;
          end else begin
            next_st.rises = st.rises + 2'h1; // [R3]
          end
        end
      end
      FCM_SPENT: begin
        // no way back short of reset, so one check per reset
        next_st = st; // [R1] [R4]
      end
      default: begin
        next_st.state = FCM_SPENT;
        next_st.rises = FCM_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.state <= FCM_ARMED; // [R7]
      st.rises <= FCM_CNT_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fuse_check_active = (st.state == FCM_ACTIVE);
  assign fuse_check_armed  = (st.state == FCM_ARMED);
  // uses the live pin so current stops in the same cycle tms rises
  assign check_current_en  = fuse_check_active & ~tms; // [R5]

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_enter;
    @(posedge clk_sys) disable iff (srst)
      (st.state == FCM_ARMED) && $past(tms) && !tms
      |=> fuse_check_active && (st.rises == FCM_CNT_RST);
  endproperty
  a_enter: assert property (p_enter) // [R2]
    else $error("mode not entered on tms fall");

  property p_stay_armed;
    @(posedge clk_sys) disable iff (srst)
      fuse_check_armed && tms |=> fuse_check_armed;
  endproperty
  a_stay_armed: assert property (p_stay_armed) // [R2]
    else $error("mode left armed without a tms fall");

  property p_first_rise;
    @(posedge clk_sys) disable iff (srst)
      fuse_check_active && (st.rises == 2'h0) && !$past(tms) && tms
      |=> fuse_check_active && (st.rises == 2'h1);
  endproperty
  a_first_rise: assert property (p_first_rise) // [R3]
    else $error("first tms rise did not keep mode active");

  property p_exit;
    @(posedge clk_sys) disable iff (srst)
      fuse_check_active && (st.rises == 2'h1) && !$past(tms) && tms
      |=> !fuse_check_active && !fuse_check_armed;
  endproperty
  a_exit: assert property (p_exit) // [R3]
    else $error("second tms rise did not end the mode");

  property p_spent;
    @(posedge clk_sys) disable iff (srst)
      $fell(fuse_check_active)
      |=> (!fuse_check_active && !fuse_check_armed) [*8];
  endproperty
  a_spent: assert property (p_spent) // [R1] [R4]
    else $error("mode re-armed or re-entered without reset");

  property p_current;
    @(posedge clk_sys) disable iff (srst)
      check_current_en |-> fuse_check_active && !tms;
  endproperty
  a_current: assert property (p_current) // [R5]
    else $error("check current enabled outside active low tms");

  property p_reset;
    @(posedge clk_sys) disable iff (srst)
      $fell(srst) |-> fuse_check_armed && !fuse_check_active
                      && (st.rises == FCM_CNT_RST) && !check_current_en;
  endproperty
  a_reset: assert property (p_reset) // [R7]
    else $error("reset did not arm the mode");

  // tms already low when reset lets go counts as a fall
  property p_enter_low;
    @(posedge clk_sys) disable iff (srst)
      $fell(srst) && !tms
      |=> fuse_check_active && (st.rises == FCM_CNT_RST);
  endproperty
  a_enter_low: assert property (p_enter_low) // [R2]
    else $error("mode not entered with tms low at reset");

  property p_fall_ignored;
    @(posedge clk_sys) disable iff (srst)
      fuse_check_active && $past(tms) && !tms
      |=> fuse_check_active && $stable(st.rises);
  endproperty
  a_fall_ignored: assert property (p_fall_ignored) // [R3]
    else $error("tms fall changed the rise count");

  property p_rises_bound;
    @(posedge clk_sys) disable iff (srst)
      fuse_check_active |-> (st.rises < FCM_RISES_TO_EXIT);
  endproperty
  a_rises_bound: assert property (p_rises_bound) // [R3]
    else $error("rise count reached exit value while active");

  property p_rises_idle;
    @(posedge clk_sys) disable iff (srst)
      !fuse_check_active |-> (st.rises == FCM_CNT_RST);
  endproperty
  a_rises_idle: assert property (p_rises_idle) // [R7]
    else $error("rise count left over outside the mode");

  // ----------------------------------------------------------------
  // checks: once per reset
  // ----------------------------------------------------------------
  // these hold for the whole cycle, unlike the fixed window above
  property p_never_rearm;
    @(posedge clk_sys) disable iff (srst)
      !fuse_check_armed |=> !fuse_check_armed;
  endproperty
  a_never_rearm: assert property (p_never_rearm) // [R1]
    else $error("mode re-armed without reset");

  property p_spent_hold;
    @(posedge clk_sys) disable iff (srst)
      !fuse_check_active && !fuse_check_armed
      |=> !fuse_check_active && !fuse_check_armed;
  endproperty
  a_spent_hold: assert property (p_spent_hold) // [R4]
    else $error("mode came back after it ended");

  // ----------------------------------------------------------------
  // checks: current path
  // ----------------------------------------------------------------
  // the on and off checks are judged against the state register, not the active output decode
  property p_current_on;
    @(posedge clk_sys) disable iff (srst)
      (st.state == FCM_ACTIVE) && !tms |-> check_current_en;
  endproperty
  a_current_on: assert property (p_current_on) // [R5]
    else $error("check current off while active with tms low");

  property p_current_off;
    @(posedge clk_sys) disable iff (srst)
      (st.state != FCM_ACTIVE) |-> !check_current_en;
  endproperty
  a_current_off: assert property (p_current_off) // [R5]
    else $error("check current on outside the mode");

  // the live pin is used, so a rise cuts the current in its own cycle
  property p_current_rise;
    @(posedge clk_sys) disable iff (srst)
      fuse_check_active && $rose(tms) |-> !check_current_en;
  endproperty
  a_current_rise: assert property (p_current_rise) // [R5]
    else $error("check current still on after tms rose");

  c_enter: cover property (@(posedge clk_sys) disable iff (srst)
    $rose(fuse_check_active));
  c_exit: cover property (@(posedge clk_sys) disable iff (srst)
    $fell(fuse_check_active));
  c_current: cover property (@(posedge clk_sys) disable iff (srst)
    check_current_en);
  c_low_entry: cover property (@(posedge clk_sys) disable iff (srst)
    $fell(srst) && !tms);

endmodule // fcm_ctrl
`default_nettype wire

/* rtl/fcm_pkg.sv */
// constants and types shared by the fuse-check mode control block
package fcm_pkg;

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  localparam int unsigned FCM_CNT_W        = 2;
  localparam logic [1:0]  FCM_RISES_TO_EXIT = 2'h2;
  localparam logic [1:0]  FCM_CNT_RST       = 2'h0;
  // tms pad is pulled up, so the edge detector assumes high before reset
  localparam logic        FCM_TMS_IDLE      = 1'h1;

  typedef enum logic [1:0] {
    FCM_ARMED  = 2'b00,
    FCM_ACTIVE = 2'b01,
    FCM_SPENT  = 2'b10
  } fcm_state_e;

endpackage

/* rtl/fcm_edge_if.sv */
// tms rise and fall pulses passed from the edge detector to the controller
`timescale 1ns/1ps
`default_nettype none
interface fcm_edge_if;
  logic tms_rise;
  logic tms_fall;

  modport src (output tms_rise, output tms_fall);
  modport snk (input  tms_rise, input  tms_fall);
endinterface
`default_nettype wire

/* rtl/fcm_tms_edge.sv */
// edge detector on the tms pin
`timescale 1ns/1ps
`default_nettype none
module fcm_tms_edge
  import fcm_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   srst,
  input  wire logic   tms,
  fcm_edge_if.src     edges
);

  typedef struct packed {
    logic prev;
  } fcm_edge_s;

  fcm_edge_s st;
  fcm_edge_s next_st;

  always_comb begin
    next_st      = st;
    next_st.prev = tms;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.prev <= FCM_TMS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // edge pulses
  // ----------------------------------------------------------------
  // tms held low through reset shows up as a fall right after release
  assign edges.tms_fall = st.prev & ~tms;
  assign edges.tms_rise = ~st.prev & tms;

endmodule // fcm_tms_edge
`default_nettype wire

/* tb/fcm_tool_model.sv */
// behavioural model of the external debug tool driving tms
`timescale 1ns/1ps
`default_nettype none
module fcm_tool_model (
  input  wire logic hold_low,
  output var  logic tms
);
  // idles high unless told to pull low, so no check current by accident
  always_comb tms = !hold_low;
endmodule // fcm_tool_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the fuse-check mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fcm_pkg::*;
  logic clk_sys;
  logic srst;
  logic hold_low;
  logic tms;
  logic act;
  logic arm;
  logic cur;
  int   mismatches;
  int   checks;

  fcm_tool_model fcm_tool_model_inst (.hold_low(hold_low), .tms(tms));
  fcm_ctrl fcm_ctrl_inst (.clk_sys(clk_sys), .srst(srst), .tms(tms),
    .fuse_check_active(act), .fuse_check_armed(arm),
    .check_current_en(cur));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk3(input logic ea, input logic er, input logic ec);
    chk("active", ea, act);
    chk("armed", er, arm);
    chk("current_en", ec, cur);
  endtask
  // new tms level lands just after the edge, checks run once it settled
  task automatic step(input logic lvl);
    @(posedge clk_sys);
    hold_low <= !lvl;
    #1;
  endtask
  task automatic rst(input logic lvl);
    @(posedge clk_sys);
    srst <= 1'b1;
    hold_low <= !lvl;
    @(posedge clk_sys);
    #1;
    chk3(1'b0, 1'b1, 1'b0);
    @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_walk;
    rst(1'b1);
    chk3(1'b0, 1'b1, 1'b0);
    step(1'b0);
    chk("current_en", 1'b0, cur);
    step(1'b0);
    chk3(1'b1, 1'b0, 1'b1);
    step(1'b1);
    chk3(1'b1, 1'b0, 1'b0);
    step(1'b1);
    step(1'b0);
    chk3(1'b1, 1'b0, 1'b1);
    step(1'b1);
    chk3(1'b1, 1'b0, 1'b0);
    step(1'b1);
    chk3(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      step(1'b0);
      chk3(1'b0, 1'b0, 1'b0);
      step(1'b1);
      chk3(1'b0, 1'b0, 1'b0);
    end
    $display("test walk done");
  endtask

  // tms held low through reset also re-arms after an earlier exit
  task automatic t_low_reset;
    rst(1'b0);
    chk3(1'b1, 1'b0, 1'b1);
    step(1'b1);
    step(1'b0);
    step(1'b1);
    step(1'b1);
    chk3(1'b0, 1'b0, 1'b0);
    $display("test low at reset done");
  endtask

  // reset while the mode is active clears it and the rise count
  task automatic t_reset_active;
    rst(1'b1);
    step(1'b0);
    step(1'b1);
    chk3(1'b1, 1'b0, 1'b0);
    step(1'b1);
    step(1'b0);
    rst(1'b1);
    step(1'b0);
    step(1'b0);
    chk3(1'b1, 1'b0, 1'b1);
    step(1'b1);
    step(1'b1);
    chk3(1'b1, 1'b0, 1'b0);
    step(1'b0);
    step(1'b1);
    step(1'b1);
    chk3(1'b0, 1'b0, 1'b0);
    $display("test reset while active done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    hold_low = 1'b0;
    mismatches = 0;
    checks = 0;
    t_walk;
    t_low_reset;
    t_reset_active;
    report_and_stop;
  end

  // the three tests need under 90 cycles
  initial begin
    #2000;
    mismatches++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
